/* core/aotpc_pkg.sv */
package aotpc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_DOWN_CONTROL = 8'h0f;
  localparam logic [7:0] ADDR_NOISE_SUPPRESSION_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_LFSR_SEED_VALUE_LOW = 8'h23;
  localparam logic [7:0] ADDR_INPUT_INVERT_AND_SEED_HIGH = 8'h24;
  localparam logic [7:0] ADDR_TEST_PATTERN_CONTROL = 8'h25;
  localparam logic [7:0] ADDR_CUSTOM_CODE_ONE_LOW = 8'h26;
  localparam logic [7:0] ADDR_CUSTOM_CODE_TWO_LOW = 8'h27;
  localparam logic [7:0] ADDR_LANE_ORDER_SELECT = 8'h28;
  localparam logic [7:0] ADDR_SYNC_PATTERN_SELECT = 8'h45;
  localparam logic [7:0] ADDR_OUTPUT_EIGHT_MAPPING = 8'h55;
  localparam logic [7:0] ADDR_DESKEW_PATTERN_SELECT = 8'hae;
  localparam logic [7:0] ADDR_REFERENCE_SELECT = 8'hf0;
  localparam logic [7:0] ADDR_STATUS = 8'hf8;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_LIGHT_SLEEP = 8;
  localparam int BIT_DEEP_SLEEP = 9;
  localparam int BIT_PIN_MODE = 10;
  localparam int BIT_RAMP = 6;
  localparam int BIT_DUAL = 5;
  localparam int BIT_SINGLE = 4;
  localparam int BIT_SOFT_ALIGN = 8;
  localparam int BIT_RANDOM = 12;
  localparam int BIT_SHORT_LFSR = 13;
  localparam int BIT_USE_SEED = 14;
  localparam int BIT_PIN_ALIGN = 15;
  localparam int BIT_BIT_WISE = 8;
  localparam int BIT_ORDER_EN = 15;
  localparam int BIT_OUTSIDE_REF = 15;
  // ---------------------------------------------------------------
  // Reset values and pattern words
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [13:0] DESKEW_WORD = 14'h1555;
  localparam logic [13:0] MARKER_WORD = 14'h3f80;
  localparam logic [22:0] LFSR_DEFAULT_SEED = 23'h7fffff;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int LIGHT_WAKE_US = 10;
  localparam int CLOCK_RUN_US = 50;
  localparam int DEEP_WAKE_US = 100;
  localparam int LIGHT_WAKE_CYCLES = LIGHT_WAKE_US * CLOCK_MHZ;
  localparam int CLOCK_RUN_CYCLES = CLOCK_RUN_US * CLOCK_MHZ;
  localparam int DEEP_WAKE_CYCLES = DEEP_WAKE_US * CLOCK_MHZ;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    PAT_NONE = 7'h01,
    PAT_RANDOM = 7'h02,
    PAT_MARKER = 7'h04,
    ALTERNATING_BITS_PATTERN = 7'h08,
    PAT_DUAL = 7'h10,
    PAT_SINGLE = 7'h20,
    PAT_RAMP = 7'h40
  } aotpc_pattern_type;

  typedef enum logic [2:0] {
    PWR_ON = 3'h1,
    PWR_WAKE = 3'h2,
    PWR_SLEEP = 3'h4
  } aotpc_power_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } aotpc_bus_type;
endpackage

/* core/aotpc_top.sv */
`timescale 1ns/10ps
// Operation
// R1 - Eight channel sleep bits each power down one converter channel.
// R2 - Light sleep wakes in 10 us once clock ran 50 us before exit.
// R3 - Leaving deep sleep takes 100 us before output is valid.
// R4 - Power register holds global light sleep and deep sleep bits.
// R5 - Sleep pin selects deep sleep when mode bit 0, light sleep when 1.
// R6 - Register 0x14 holds one noise shift enable per channel.
// R7 - Input swap bits invert polarity of that channel's data.
// R8 - Any enabled pattern replaces converted data on outputs.
// R9 - Pin align enable lets the sync pin restart pattern generators.
// R10 - Software align bit needs special write timing from software.
// R11 - Ramp counts from zero by one each sample and wraps.
// R12 - Single mode outputs first user code on every sample.
// R13 - Dual mode alternates first and second user codes.
// R14 - Deskew mode outputs alternating zero one word.
// R15 - Marker mode outputs seven ones then seven zeros.
// R16 - Random mode outputs 23-bit LFSR, or 9-bit when short select set.
// R17 - Programmed seed comes from registers 0x24 and 0x23 when selected.
// R18 - Software enables at most one pattern mode at a time.
// R19 - Register 0x28 picks bit, byte or word lane split per channel.
// R20 - Bit 15 of register 0xf0 selects the outside reference.
// R21 - Register 0x55 holds sources of pair eight B and A.
// R22 - Host waits about 250 us after changing lane mode.
// R23 - Several pattern enables resolve by fixed priority to one pattern.
module aotpc_top #(
  parameter int LIGHT_WAKE = aotpc_pkg::LIGHT_WAKE_CYCLES,
  parameter int CLOCK_RUN = aotpc_pkg::CLOCK_RUN_CYCLES,
  parameter int DEEP_WAKE = aotpc_pkg::DEEP_WAKE_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  // Device pins and converter data
  input wire logic SLEEP_PIN_IN,
  input wire logic SYNC_PIN_IN,
  input wire logic SAMPLE_CLK_IN,
  input wire logic [13:0] CONV_DATA_IN,
  // Output stream and controls
  output logic [13:0] SAMPLE_OUT,
  output logic SAMPLE_VALID_OUT,
  output logic [7:0] CHANNEL_ON_OUT,
  output logic [7:0] NOISE_SHIFT_OUT,
  output logic [7:0] INPUT_SWAP_OUT,
  output logic OUTPUT_READY_OUT,
  output logic OUTSIDE_REF_OUT,
  output logic [15:0] LANE_ORDER_OUT,
  output logic [7:0] PAIR_EIGHT_SOURCE_OUT
);
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  aotpc_pkg::aotpc_bus_type bus;
  logic [15:0] pwr_r, nsh_r, seedl_r, invh_r, tpc_r, cu1_r, cu2_r;
  logic [15:0] lane_r, mark_r, map_r, desk_r, ref_r;
  logic [15:0] rd_mux;
  logic [15:0] status_word;
  logic hit_status;

  // Bus signals grouped for decoding.
  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // Register writes; every register resets to zero.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pwr_r <= aotpc_pkg::REG_RESET;
      nsh_r <= aotpc_pkg::REG_RESET;
      seedl_r <= aotpc_pkg::REG_RESET;
      invh_r <= aotpc_pkg::REG_RESET;
      tpc_r <= aotpc_pkg::REG_RESET;
      cu1_r <= aotpc_pkg::REG_RESET;
      cu2_r <= aotpc_pkg::REG_RESET;
      lane_r <= aotpc_pkg::REG_RESET;
      mark_r <= aotpc_pkg::REG_RESET;
      map_r <= aotpc_pkg::REG_RESET;
      desk_r <= aotpc_pkg::REG_RESET;
      ref_r <= aotpc_pkg::REG_RESET;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        aotpc_pkg::ADDR_POWER_DOWN_CONTROL: pwr_r <= {5'h00, bus.wdata[10:0]}; // R1 R4
        aotpc_pkg::ADDR_NOISE_SUPPRESSION_ENABLE: nsh_r <= {8'h00, bus.wdata[7:0]}; // R6
        aotpc_pkg::ADDR_LFSR_SEED_VALUE_LOW: seedl_r <= bus.wdata; // R17
        aotpc_pkg::ADDR_INPUT_INVERT_AND_SEED_HIGH: invh_r <= {bus.wdata[15:9], 1'b0, bus.wdata[7:0]}; // R7
        aotpc_pkg::ADDR_TEST_PATTERN_CONTROL: tpc_r <= {bus.wdata[15:12], 3'h0, bus.wdata[8], 4'h0, bus.wdata[3:0]};
        aotpc_pkg::ADDR_CUSTOM_CODE_ONE_LOW: cu1_r <= {bus.wdata[15:4], 4'h0};
        aotpc_pkg::ADDR_CUSTOM_CODE_TWO_LOW: cu2_r <= {bus.wdata[15:4], 4'h0};
        aotpc_pkg::ADDR_LANE_ORDER_SELECT: lane_r <= {bus.wdata[15], 6'h00, bus.wdata[8:0]}; // R19
        aotpc_pkg::ADDR_SYNC_PATTERN_SELECT: mark_r <= {14'h0000, bus.wdata[1], 1'b0}; // R15
        aotpc_pkg::ADDR_OUTPUT_EIGHT_MAPPING: map_r <= {8'h00, bus.wdata[7:0]}; // R21
        aotpc_pkg::ADDR_DESKEW_PATTERN_SELECT: desk_r <= {15'h0000, bus.wdata[0]}; // R14
        aotpc_pkg::ADDR_REFERENCE_SELECT: ref_r <= {bus.wdata[15], 15'h0000}; // R20
        default: ;
      endcase
    end
  end

  // Read selection; unmapped addresses read zero.
  assign hit_status = bus.addr == aotpc_pkg::ADDR_STATUS;
  assign rd_mux = (bus.addr == aotpc_pkg::ADDR_POWER_DOWN_CONTROL) ? pwr_r :
                  (bus.addr == aotpc_pkg::ADDR_NOISE_SUPPRESSION_ENABLE) ? nsh_r :
                  (bus.addr == aotpc_pkg::ADDR_LFSR_SEED_VALUE_LOW) ? seedl_r :
                  (bus.addr == aotpc_pkg::ADDR_INPUT_INVERT_AND_SEED_HIGH) ? invh_r :
                  (bus.addr == aotpc_pkg::ADDR_TEST_PATTERN_CONTROL) ? tpc_r :
                  (bus.addr == aotpc_pkg::ADDR_CUSTOM_CODE_ONE_LOW) ? cu1_r :
                  (bus.addr == aotpc_pkg::ADDR_CUSTOM_CODE_TWO_LOW) ? cu2_r :
                  (bus.addr == aotpc_pkg::ADDR_LANE_ORDER_SELECT) ? lane_r :
                  (bus.addr == aotpc_pkg::ADDR_SYNC_PATTERN_SELECT) ? mark_r :
                  (bus.addr == aotpc_pkg::ADDR_OUTPUT_EIGHT_MAPPING) ? map_r :
                  (bus.addr == aotpc_pkg::ADDR_DESKEW_PATTERN_SELECT) ? desk_r :
                  (bus.addr == aotpc_pkg::ADDR_REFERENCE_SELECT) ? ref_r :
                  hit_status ? status_word : 16'h0000;

  // Read data stands for the one cycle after the strobe.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      RDATA_OUT <= 16'h0000;
    else if (bus.rd)
      RDATA_OUT <= rd_mux;
    else
      RDATA_OUT <= 16'h0000;
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and sample clock edge
  // ---------------------------------------------------------------
  logic [1:0] slp_s_r, syn_s_r, sck_s_r;
  logic sck_d_r, syn_d_r;
  logic sample_tick, sync_rise;

  // Two flops per pin before any logic looks at it.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      slp_s_r <= 2'h0;
      syn_s_r <= 2'h0;
      sck_s_r <= 2'h0;
      sck_d_r <= 1'b0;
      syn_d_r <= 1'b0;
    end
    else
    begin
      slp_s_r <= {slp_s_r[0], SLEEP_PIN_IN};
      syn_s_r <= {syn_s_r[0], SYNC_PIN_IN};
      sck_s_r <= {sck_s_r[0], SAMPLE_CLK_IN};
      sck_d_r <= sck_s_r[1];
      syn_d_r <= syn_s_r[1];
    end
  end

  // Rising sample clock marks one sample; a rising sync pin aligns patterns.
  assign sample_tick = sck_s_r[1] & ~sck_d_r;
  assign sync_rise = syn_s_r[1] & ~syn_d_r;

  // ---------------------------------------------------------------
  // Power sequencing
  // ---------------------------------------------------------------
  aotpc_pkg::aotpc_power_type pwr_st_r, pwr_st_nxt;
  logic light_req, deep_req, deep_seen_r, clk_ok;
  logic [31:0] wake_cnt_r, run_cnt_r;
  logic [31:0] wake_len;

  // Pin acts as deep or light sleep depending on the mode bit.
  assign light_req = pwr_r[aotpc_pkg::BIT_LIGHT_SLEEP] |
                     (slp_s_r[1] & pwr_r[aotpc_pkg::BIT_PIN_MODE]); // R4 R5
  assign deep_req = pwr_r[aotpc_pkg::BIT_DEEP_SLEEP] |
                    (slp_s_r[1] & ~pwr_r[aotpc_pkg::BIT_PIN_MODE]); // R4 R5
  assign clk_ok = run_cnt_r >= 32'(CLOCK_RUN);
  // Light wake only counts short if the sample clock ran long enough first.
  assign wake_len = (deep_seen_r | !clk_ok) ? 32'(DEEP_WAKE) : 32'(LIGHT_WAKE); // R2 R3

  // Next power state.
  always_comb
  begin
    pwr_st_nxt = pwr_st_r;
    case (pwr_st_r)
      aotpc_pkg::PWR_ON: if (light_req | deep_req) pwr_st_nxt = aotpc_pkg::PWR_SLEEP;
      aotpc_pkg::PWR_SLEEP: if (!(light_req | deep_req)) pwr_st_nxt = aotpc_pkg::PWR_WAKE;
      aotpc_pkg::PWR_WAKE:
        if (light_req | deep_req) pwr_st_nxt = aotpc_pkg::PWR_SLEEP;
        else if (wake_cnt_r >= wake_len - 32'd1) pwr_st_nxt = aotpc_pkg::PWR_ON;
      default: pwr_st_nxt = aotpc_pkg::PWR_ON;
    endcase
  end

  // Power state, wake counter and sample clock run counter.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pwr_st_r <= aotpc_pkg::PWR_ON;
      wake_cnt_r <= 32'd0;
      run_cnt_r <= 32'd0;
      deep_seen_r <= 1'b0;
    end
    else
    begin
      pwr_st_r <= pwr_st_nxt;
      wake_cnt_r <= (pwr_st_r == aotpc_pkg::PWR_WAKE) ? wake_cnt_r + 32'd1 : 32'd0;
      if (sample_tick && !clk_ok)
        run_cnt_r <= run_cnt_r + 32'd1;
      if (pwr_st_r == aotpc_pkg::PWR_SLEEP)
        deep_seen_r <= deep_seen_r | deep_req;
      else if (pwr_st_r == aotpc_pkg::PWR_ON)
        deep_seen_r <= 1'b0;
    end
  end

  assign status_word = {13'h0000, pwr_st_r};

  // ---------------------------------------------------------------
  // Pattern generation
  // ---------------------------------------------------------------
  aotpc_pkg::aotpc_pattern_type pat_sel;
  logic [13:0] code_one, code_two, ramp_r, conv_word, pat_word;
  logic [22:0] lfsr_r, lfsr_next, lfsr_seed;
  logic toggle_r, align, pin_align;

  assign code_one = {tpc_r[1:0], cu1_r[15:4]};
  assign code_two = {tpc_r[3:2], cu2_r[15:4]};
  assign lfsr_seed = tpc_r[aotpc_pkg::BIT_USE_SEED] ? {invh_r[15:9], seedl_r} :
                     aotpc_pkg::LFSR_DEFAULT_SEED; // R17
  // Short mode taps x^9+x^5+1, long mode x^23+x^18+1.
  assign lfsr_next = tpc_r[aotpc_pkg::BIT_SHORT_LFSR] ?
                     {14'h0000, lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]} :
                     {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]}; // R16
  assign pin_align = tpc_r[aotpc_pkg::BIT_PIN_ALIGN] & sync_rise; // R9
  assign align = pin_align | tpc_r[aotpc_pkg::BIT_SOFT_ALIGN]; // R10

  // Fixed priority so only one pattern ever reaches the output.
  assign pat_sel = tpc_r[aotpc_pkg::BIT_RANDOM] ? aotpc_pkg::PAT_RANDOM :
                   mark_r[1] ? aotpc_pkg::PAT_MARKER :
                   desk_r[0] ? aotpc_pkg::ALTERNATING_BITS_PATTERN :
                   invh_r[aotpc_pkg::BIT_DUAL] ? aotpc_pkg::PAT_DUAL :
                   invh_r[aotpc_pkg::BIT_SINGLE] ? aotpc_pkg::PAT_SINGLE :
                   invh_r[aotpc_pkg::BIT_RAMP] ? aotpc_pkg::PAT_RAMP :
                   aotpc_pkg::PAT_NONE; // R23

  // Channel zero data, inverted when its swap bit is set.
  assign conv_word = invh_r[0] ? ~CONV_DATA_IN : CONV_DATA_IN; // R7

  // Pattern word selection.
  always_comb
  begin
    case (pat_sel)
      aotpc_pkg::PAT_RANDOM: pat_word = lfsr_r[13:0]; // R16
      aotpc_pkg::PAT_MARKER: pat_word = aotpc_pkg::MARKER_WORD; // R15
      aotpc_pkg::ALTERNATING_BITS_PATTERN: pat_word = aotpc_pkg::DESKEW_WORD; // R14
      aotpc_pkg::PAT_DUAL: pat_word = toggle_r ? code_two : code_one; // R13
      aotpc_pkg::PAT_SINGLE: pat_word = code_one; // R12
      aotpc_pkg::PAT_RAMP: pat_word = ramp_r; // R11
      default: pat_word = conv_word; // R8
    endcase
  end

  // Ramp, toggle and LFSR advance once per sample; alignment restarts them.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ramp_r <= 14'h0000;
      toggle_r <= 1'b0;
      lfsr_r <= aotpc_pkg::LFSR_DEFAULT_SEED;
    end
    else if (align)
    begin
      ramp_r <= 14'h0000;
      toggle_r <= 1'b0;
      lfsr_r <= lfsr_seed;
    end
    else if (pat_sel != aotpc_pkg::PAT_RANDOM && !sample_tick)
      lfsr_r <= lfsr_seed;
    else if (sample_tick)
    begin
      ramp_r <= ramp_r + 14'h0001; // R11
      toggle_r <= ~toggle_r; // R13
      lfsr_r <= lfsr_next; // R16
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      SAMPLE_OUT <= 14'h0000;
      SAMPLE_VALID_OUT <= 1'b0;
      CHANNEL_ON_OUT <= 8'h00;
      NOISE_SHIFT_OUT <= 8'h00;
      INPUT_SWAP_OUT <= 8'h00;
      OUTPUT_READY_OUT <= 1'b0;
      OUTSIDE_REF_OUT <= 1'b0;
      LANE_ORDER_OUT <= 16'h0000;
      PAIR_EIGHT_SOURCE_OUT <= 8'h00;
    end
    else
    begin
      SAMPLE_OUT <= sample_tick ? pat_word : SAMPLE_OUT;
      SAMPLE_VALID_OUT <= sample_tick & (pwr_st_r == aotpc_pkg::PWR_ON);
      // Whole chip sleep powers every channel down.
      CHANNEL_ON_OUT <= (pwr_st_r == aotpc_pkg::PWR_SLEEP) ? 8'h00 : ~pwr_r[7:0]; // R1
      NOISE_SHIFT_OUT <= nsh_r[7:0]; // R6
      INPUT_SWAP_OUT <= invh_r[7:0]; // R7
      OUTPUT_READY_OUT <= pwr_st_r == aotpc_pkg::PWR_ON; // R2 R3
      OUTSIDE_REF_OUT <= ref_r[aotpc_pkg::BIT_OUTSIDE_REF]; // R20
      LANE_ORDER_OUT <= lane_r; // R19
      PAIR_EIGHT_SOURCE_OUT <= map_r[7:0]; // R21
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_deskew_word: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R14
    sample_tick && pat_sel == aotpc_pkg::ALTERNATING_BITS_PATTERN |=> SAMPLE_OUT == 14'h1555)
    else $error("deskew word wrong");
  a_marker_word: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R15
    sample_tick && pat_sel == aotpc_pkg::PAT_MARKER |=> SAMPLE_OUT == 14'h3f80)
    else $error("marker word wrong");
  a_single_code: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R12
    sample_tick && pat_sel == aotpc_pkg::PAT_SINGLE |=> SAMPLE_OUT == $past(code_one))
    else $error("single code wrong");
  a_ramp_step: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R11
    sample_tick && !align |=> ramp_r == $past(ramp_r) + 14'h0001)
    else $error("ramp did not step");
  a_dual_toggle: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R13
    sample_tick && !align |=> toggle_r != $past(toggle_r))
    else $error("dual toggle stuck");
  a_pin_deep: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R5
    slp_s_r[1] && !pwr_r[aotpc_pkg::BIT_PIN_MODE] |-> deep_req)
    else $error("pin not deep sleep");
  a_sleep_chan_off: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R1
    pwr_st_r == aotpc_pkg::PWR_SLEEP |=> CHANNEL_ON_OUT == 8'h00)
    else $error("channels on in sleep");
  a_pin_align: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R9
    pin_align |=> ramp_r == 14'h0000)
    else $error("pin align ignored");
  a_read_data: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R20
    bus.rd && bus.addr == aotpc_pkg::ADDR_REFERENCE_SELECT |=> RDATA_OUT == $past(ref_r))
    else $error("read data wrong");
  c_ramp: cover property (@(posedge CLOCK_IN) pat_sel == aotpc_pkg::PAT_RAMP && sample_tick);
  c_random: cover property (@(posedge CLOCK_IN) pat_sel == aotpc_pkg::PAT_RANDOM && sample_tick);
  c_wake: cover property (@(posedge CLOCK_IN) pwr_st_r == aotpc_pkg::PWR_WAKE ##1
    pwr_st_r == aotpc_pkg::PWR_ON);
  a_random_word: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R16
    sample_tick && pat_sel == aotpc_pkg::PAT_RANDOM |=> SAMPLE_OUT == $past(lfsr_r[13:0]))
    else $error("random word wrong");
  a_dual_word: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R13
    sample_tick && pat_sel == aotpc_pkg::PAT_DUAL |=>
    SAMPLE_OUT == ($past(toggle_r) ? $past(code_two) : $past(code_one)))
    else $error("dual word wrong");
  a_data_pass: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R8
    sample_tick && pat_sel == aotpc_pkg::PAT_NONE |=> SAMPLE_OUT == $past(conv_word))
    else $error("converted word wrong");
  a_sleep_not_ready: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) // R2 R3
    pwr_st_r != aotpc_pkg::PWR_ON |=> !OUTPUT_READY_OUT)
    else $error("ready while not powered");
  // Further scenarios the bench is expected to reach.
  c_dual: cover property (@(posedge CLOCK_IN) pat_sel == aotpc_pkg::PAT_DUAL && sample_tick);
  c_pin_sleep: cover property (@(posedge CLOCK_IN) slp_s_r[1] && pwr_st_r == aotpc_pkg::PWR_SLEEP);
endmodule // aotpc_top

/* verification/aotpc_receiver_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Receiver that captures the output word stream
// ---------------------------------------------------------------
module aotpc_receiver_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Captured stream
  input wire logic [13:0] sample_in,
  input wire logic sample_valid_in,
  output logic [13:0] last_word_out,
  output int word_count_out
);
  // Takes a word only on the valid pulse, as a capturing receiver would.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last_word_out <= 14'h0000;
      word_count_out <= 0;
    end
    else if (sample_valid_in)
    begin
      last_word_out <= sample_in;
      word_count_out <= word_count_out + 1;
    end
  end
endmodule // aotpc_receiver_model

/* verification/test_adc_output_test_pattern_ctrl.sv */
`timescale 1ns/10ps
module test_adc_output_test_pattern_ctrl;
  // ---------------------------------------------------------------
  // Signals and tables
  // ---------------------------------------------------------------
  localparam int LW = 10;
  localparam int DW = 40;
  localparam logic [7:0] AD [12] = '{8'h0f, 8'h14, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h45, 8'h55, 8'hae, 8'hf0};
  localparam logic [15:0] MK [12] = '{16'h07ff, 16'h00ff, 16'hffff, 16'hfeff, 16'hf10f, 16'hfff0, 16'hfff0, 16'h81ff,
    16'h0002, 16'h00ff, 16'h0001, 16'h8000};
  aotpc_pkg::aotpc_bus_type bus;
  logic clock, rst_n, sleep_pin, sync_pin, sample_clk, valid, ready, oref;
  logic [13:0] conv, sample, last_word, w, w2;
  logic [13:0] wv [0:511];
  logic [15:0] rdata, lane;
  logic [7:0] ch_on, noise, swap, pair;
  int count, bad_count, tests_run, cycles, i;

  // Device under test with short wake counts.
  aotpc_top #(.LIGHT_WAKE(LW), .CLOCK_RUN(20), .DEEP_WAKE(DW)) aotpc_top_i (.CLOCK_IN(clock), .RST_N_IN(rst_n),
    .ADDR_IN(bus.addr), .WDATA_IN(bus.wdata), .WR_IN(bus.wr), .RD_IN(bus.rd), .RDATA_OUT(rdata),
    .SLEEP_PIN_IN(sleep_pin), .SYNC_PIN_IN(sync_pin), .SAMPLE_CLK_IN(sample_clk), .CONV_DATA_IN(conv),
    .SAMPLE_OUT(sample), .SAMPLE_VALID_OUT(valid), .CHANNEL_ON_OUT(ch_on), .NOISE_SHIFT_OUT(noise),
    .INPUT_SWAP_OUT(swap), .OUTPUT_READY_OUT(ready), .OUTSIDE_REF_OUT(oref), .LANE_ORDER_OUT(lane),
    .PAIR_EIGHT_SOURCE_OUT(pair));

  // Far side receiver.
  aotpc_receiver_model aotpc_receiver_model_i (.clock_in(clock), .rst_n_in(rst_n), .sample_in(sample),
    .sample_valid_in(valid), .last_word_out(last_word), .word_count_out(count));

  // ---------------------------------------------------------------
  // Clocks and timeout
  // ---------------------------------------------------------------
  always #5 clock = ~clock;

  // The sample clock runs free at 160 ns with an unrelated phase.
  initial
  begin
    sample_clk = 1'b0;
    #3;
    forever #80 sample_clk = ~sample_clk;
  end

  // Cuts a hung run short.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      bad_count++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(logic [15:0] g, logic [15:0] e, string m);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(logic [7:0] a, logic [15:0] e);
    @(posedge clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk(rdata, e, "read data");
  endtask

  // Waits for the next captured word, bounded.
  task automatic next_word(output logic [13:0] nw);
    int c;
    c = count;
    for (int k = 0; k < 100 && count == c; k++)
    begin
      @(posedge clock);
      #1;
    end
    chk(16'(count != c), 16'h0001, "word arrived");
    nw = last_word;
  endtask

  task automatic words(int n);
    repeat (n) next_word(w);
  endtask

  // Counts cycles until the output is ready again.
  task automatic wake_chk(int e);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 500)
    begin
      @(posedge clock);
      n++;
    end
    chk(16'(n > e - 4 && n < e + 4), 16'h0001, "wake time");
  endtask

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    sleep_pin = 1'b0;
    sync_pin = 1'b0;
    conv = 14'h2a5c;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++) rd_chk(AD[i], 16'h0000);
    chk(16'(oref), 16'h0000, "reference");
    for (i = 0; i < 12; i++)
    begin
      wr(AD[i], 16'hffff);
      rd_chk(AD[i], MK[i]);
    end
    wr(8'h30, 16'hffff);
    rd_chk(8'h30, 16'h0000);
    chk({ch_on, noise}, 16'h00ff, "channel and noise mirrors");
    chk({swap, pair}, 16'hffff, "swap and pair mirrors");
    chk(lane, 16'h81ff, "lane mirror");
    chk(16'(oref), 16'h0001, "reference");
    for (i = 11; i >= 0; i--) wr(AD[i], 16'h0000);
    wake_chk(DW);
    wr(8'h0f, 16'h00a5);
    repeat (2) @(posedge clock);
    #1 chk(16'(ch_on), 16'h005a, "channel on");
    wr(8'h0f, 16'h0100);
    repeat (400) @(posedge clock);
    chk({ch_on, 7'h00, ready}, 16'h0000, "light sleep");
    rd_chk(8'hf8, 16'h0004);
    wr(8'h0f, 16'h0000);
    wake_chk(LW);
    wr(8'h0f, 16'h0200);
    repeat (400) @(posedge clock);
    wr(8'h0f, 16'h0000);
    wake_chk(DW);
    sleep_pin <= 1'b1;
    repeat (400) @(posedge clock);
    rd_chk(8'hf8, 16'h0004);
    sleep_pin <= 1'b0;
    // The pin passes two sync flops, so waking from it takes two cycles more.
    wake_chk(DW + 2);
    wr(8'h0f, 16'h0400);
    sleep_pin <= 1'b1;
    repeat (400) @(posedge clock);
    sleep_pin <= 1'b0;
    wake_chk(LW + 2);
    words(2);
    chk(16'(w), 16'h2a5c, "converted data");
    wr(8'h24, 16'h0001);
    words(3);
    chk(16'(w), 16'h15a3, "swapped input");
    wr(8'h45, 16'h0002);
    wr(8'hae, 16'h0001);
    words(3);
    chk(16'(w), 16'h3f80, "marker over deskew");
    wr(8'h45, 16'h0000);
    words(3);
    chk(16'(w), 16'h1555, "deskew word");
    wr(8'hae, 16'h0000);
    wr(8'h26, 16'hd3b0);
    wr(8'h27, 16'h2c40);
    wr(8'h25, 16'h0006);
    wr(8'h24, 16'h0010);
    words(3);
    chk(16'(w), 16'h2d3b, "first user code");
    wr(8'h24, 16'h0020);
    words(3);
    next_word(w2);
    chk(16'(w2), (w == 14'h2d3b) ? 16'h12c4 : 16'h2d3b, "toggled code");
    wr(8'h24, 16'h0040);
    words(40);
    next_word(w2);
    chk(16'(w2), 16'(w + 14'h0001), "ramp step");
    wr(8'h25, 16'h8000);
    sync_pin <= 1'b1;
    repeat (5) @(posedge clock);
    sync_pin <= 1'b0;
    words(2);
    chk(16'(w < 14'h0004), 16'h0001, "ramp restarted");
    wr(8'h23, 16'h5a3c);
    wr(8'h24, 16'h5600);
    wr(8'h25, 16'h5100);
    words(3);
    chk(16'(w), 16'h1a3c, "seeded start");
    wr(8'h25, 16'h1000);
    words(20);
    for (i = 0; i < 512; i++) next_word(wv[i]);
    chk({15'h0000, wv[1] != wv[0] && wv[511] != wv[0]}, 16'h0001, "long sequence");
    // Leaving random mode reloads the seed, so the short register never starts at zero.
    wr(8'h25, 16'h0000);
    wr(8'h25, 16'h3000);
    words(20);
    for (i = 0; i < 512; i++) next_word(wv[i]);
    chk({15'h0000, wv[1] != wv[0] && wv[511] == wv[0]}, 16'h0001, "short period");
    final_report();
  end
endmodule // test_adc_output_test_pattern_ctrl
